// [spu_cfg.svh]
// Timing, sizing and reset constants for the serial port
`ifndef SPU_CFG_SVH
`define SPU_CFG_SVH
`define SPU_CLK_HZ 125000000
`define SPU_MS_PER_S 1000
`define SPU_RTS_MS_MAX 100
`define SPU_FIFO_DEPTH 16
`define SPU_CNT_W 24
`define SPU_RATE_COUNT 20
`define SPU_DEFAULT_RATE 16
`define SPU_DATA_TOP8 3'h7
`define SPU_DATA_TOP7 3'h6
`define SPU_IDLE_LINE 1'b1
`endif

// [spu_pkg.sv]
// Types shared by the serial port files
package spu_pkg;
    typedef enum logic [2:0] {
        SPU_PAR_NONE, SPU_PAR_ODD, SPU_PAR_EVEN, SPU_PAR_MARK, SPU_PAR_SPACE
    } spu_parity_t;
    typedef enum logic [1:0] {SPU_FLOW_NONE, SPU_FLOW_RTSCTS, SPU_FLOW_TOGGLE} spu_flow_t;
    typedef enum logic [1:0] {SPU_LINE_232, SPU_LINE_422, SPU_LINE_485_2W, SPU_LINE_485_4W} spu_line_t;
    typedef struct packed {
        logic [4:0] rate_sel;
        spu_parity_t parity;
        logic data8;
        logic stop2;
        spu_flow_t flow;
        logic fifo_en;
        spu_line_t line;
        logic [6:0] rts_on_ms;
        logic [6:0] rts_off_ms;
    } spu_cfg_t;
    typedef struct packed {
        logic [7:0] data;
        logic parity_err;
        logic frame_err;
    } spu_rx_word_t;
endpackage : spu_pkg

// [spu_fifo.sv]
// Character FIFO with registered output stage
`timescale 1ns/100ps
module spu_fifo #(
    parameter int WIDTH = 10,
    parameter int DEPTH = 16
) (
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic clk_en,
    input wire logic in_valid,
    input wire logic [WIDTH-1:0] in_data,
    output logic in_ready,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data,
    output logic empty
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr_reg, wr_ptr_next, rd_ptr_reg, rd_ptr_next;
    logic [AW:0] cnt_reg, cnt_next;
    logic out_valid_reg, out_valid_next;
    logic [WIDTH-1:0] out_data_reg, out_data_next;
    logic wr, load;

    assign in_ready = cnt_reg != (AW+1)'(DEPTH);
    assign out_valid = out_valid_reg;
    assign out_data = out_data_reg;
    assign empty = (cnt_reg == '0) && !out_valid_reg;

    always_comb begin
        wr = in_valid && in_ready;
        load = (cnt_reg != '0) && (!out_valid_reg || out_ready);
        wr_ptr_next = wr ? AW'(wr_ptr_reg + 1'b1) : wr_ptr_reg;
        rd_ptr_next = load ? AW'(rd_ptr_reg + 1'b1) : rd_ptr_reg;
        cnt_next = (AW+1)'(cnt_reg + (AW+1)'(wr) - (AW+1)'(load));
        out_data_next = load ? mem[rd_ptr_reg] : out_data_reg;
        out_valid_next = load ? 1'b1 : (out_ready ? 1'b0 : out_valid_reg);
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            cnt_reg <= '0;
            out_valid_reg <= 1'b0;
            out_data_reg <= '0;
        end else if (clk_en) begin
            wr_ptr_reg <= wr_ptr_next;
            rd_ptr_reg <= rd_ptr_next;
            cnt_reg <= cnt_next;
            out_valid_reg <= out_valid_next;
            out_data_reg <= out_data_next;
        end
    end

    always_ff @(posedge clock) begin
        if (clk_en && wr) begin
            mem[wr_ptr_reg] <= in_data;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge clock); endclocking
    default disable iff (sys_rst);
    fill_bound_a: assert property (cnt_reg <= (AW+1)'(DEPTH))
        else $error("fifo count above depth");
    full_refuse_a: assert property (clk_en && !in_ready && !load |=> cnt_reg == $past(cnt_reg))
        else $error("fifo took a word while full");
    out_hold_a: assert property (clk_en && out_valid && !out_ready |=> out_valid && $stable(out_data))
        else $error("fifo output dropped before taken");
    fifo_full_c: cover property (!in_ready);
endmodule : spu_fifo

// [spu_uart.sv]
// Serial port with parity, line modes, RTS/CTS and timed RTS toggle
`timescale 1ns/100ps
`include "spu_cfg.svh"
// How it works
// - Rates 50 to 921.6k, 7/8 data, 1/2 stop
// - Parity none, odd, even, mark, space
// - Line mode selects driver and receiver enables
// - Toggle mode: RTS off without pending data
// - Toggle mode: RTS on, wait lead, then start
// - Toggle mode: hold RTS for lag after stop
// - Toggle mode only honoured on RS-232
// - Lead and lag matter only in toggle mode
module spu_uart #(
    parameter int CYC_PER_MS = `SPU_CLK_HZ / `SPU_MS_PER_S,
    parameter int DEPTH = `SPU_FIFO_DEPTH
) (
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic clk_en,
    input wire spu_pkg::spu_cfg_t cfg,
    input wire logic tx_valid,
    input wire logic [7:0] tx_data,
    output logic tx_ready,
    output logic rx_valid,
    output spu_pkg::spu_rx_word_t rx_word,
    input wire logic rx_ready,
    output logic rx_overrun,
    input wire logic rxd,
    input wire logic cts,
    output logic txd,
    output logic rts,
    output logic drv_en,
    output logic rcv_en
);
    localparam int CW = `SPU_CNT_W;
    localparam logic [CW-1:0] BIT_CYC [`SPU_RATE_COUNT] = '{
        CW'(`SPU_CLK_HZ / 50), CW'(`SPU_CLK_HZ / 75), CW'(`SPU_CLK_HZ / 110),
        CW'(`SPU_CLK_HZ / 134), CW'(`SPU_CLK_HZ / 150), CW'(`SPU_CLK_HZ / 300),
        CW'(`SPU_CLK_HZ / 600), CW'(`SPU_CLK_HZ / 1200), CW'(`SPU_CLK_HZ / 1800),
        CW'(`SPU_CLK_HZ / 2400), CW'(`SPU_CLK_HZ / 4800), CW'(`SPU_CLK_HZ / 7200),
        CW'(`SPU_CLK_HZ / 9600), CW'(`SPU_CLK_HZ / 19200), CW'(`SPU_CLK_HZ / 38400),
        CW'(`SPU_CLK_HZ / 57600), CW'(`SPU_CLK_HZ / 115200), CW'(`SPU_CLK_HZ / 230400),
        CW'(`SPU_CLK_HZ / 460800), CW'(`SPU_CLK_HZ / 921600)};

    typedef enum logic [2:0] {S_IDLE, S_LEAD, S_WAIT, S_START, S_DATA, S_PARITY, S_STOP, S_LAG}
        spu_tx_state_t;
    typedef enum logic [2:0] {R_IDLE, R_START, R_DATA, R_PARITY, R_STOP, R_BREAK} spu_rx_state_t;

    function automatic logic [CW-1:0] spu_bit_cycles(input logic [4:0] sel);
        // Unlisted selections fall back to the default rate
        spu_bit_cycles = (sel < 5'(`SPU_RATE_COUNT)) ? BIT_CYC[sel] : BIT_CYC[`SPU_DEFAULT_RATE];
    endfunction : spu_bit_cycles

    function automatic logic [CW-1:0] spu_ms_cycles(input logic [6:0] ms);
        logic [6:0] lim;
        lim = (ms > 7'(`SPU_RTS_MS_MAX)) ? 7'(`SPU_RTS_MS_MAX) : ms;
        spu_ms_cycles = CW'(lim * CYC_PER_MS);
    endfunction : spu_ms_cycles

    function automatic logic spu_parity(input logic [7:0] d, input spu_pkg::spu_parity_t m,
                                        input logic d8);
        logic [7:0] v;
        v = d8 ? d : {1'b0, d[6:0]};
        case (m)
            spu_pkg::SPU_PAR_ODD: spu_parity = ~^v;
            spu_pkg::SPU_PAR_EVEN: spu_parity = ^v;
            spu_pkg::SPU_PAR_MARK: spu_parity = 1'b1;
            default: spu_parity = 1'b0;
        endcase
    endfunction : spu_parity

    ////////////////////////////////////////////////////////////////////////////
    logic rxd_s1, rxd_s, cts_s1, cts_s;
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            rxd_s1 <= `SPU_IDLE_LINE;
            rxd_s <= `SPU_IDLE_LINE;
            cts_s1 <= 1'b0;
            cts_s <= 1'b0;
        end else if (clk_en) begin
            rxd_s1 <= rxd;
            rxd_s <= rxd_s1;
            cts_s1 <= cts;
            cts_s <= cts_s1;
        end
    end

    logic is_232, eff_toggle, eff_hs, is_485;
    logic fifo_in_ready, fifo_empty, accept_ok, push;
    spu_pkg::spu_rx_word_t push_word;
    logic [CW-1:0] bit_cyc;

    assign is_232 = cfg.line == spu_pkg::SPU_LINE_232;
    assign eff_toggle = is_232 && (cfg.flow == spu_pkg::SPU_FLOW_TOGGLE);
    assign eff_hs = is_232 && (cfg.flow == spu_pkg::SPU_FLOW_RTSCTS);
    assign is_485 = (cfg.line == spu_pkg::SPU_LINE_485_2W) || (cfg.line == spu_pkg::SPU_LINE_485_4W);
    assign bit_cyc = spu_bit_cycles(cfg.rate_sel);
    // Without FIFO only an empty path accepts, trading throughput for latency
    assign accept_ok = cfg.fifo_en ? fifo_in_ready : fifo_empty;

    ////////////////////////////////////////////////////////////////////////////
    spu_tx_state_t tx_state_reg, tx_state_next;
    logic [CW-1:0] tx_cnt_reg, tx_cnt_next, dly_reg, dly_next;
    logic [2:0] tx_idx_reg, tx_idx_next;
    logic [7:0] tx_sh_reg, tx_sh_next;
    logic tx_par_reg, tx_par_next, txd_reg, txd_next, rts_reg, rts_next;
    logic tx_ready_reg, tx_ready_next, drv_reg, drv_next, rcv_reg, rcv_next;
    logic tx_end;

    always_comb begin
        tx_state_next = tx_state_reg;
        tx_cnt_next = (tx_cnt_reg == '0) ? CW'(bit_cyc - 1'b1) : CW'(tx_cnt_reg - 1'b1);
        dly_next = dly_reg;
        tx_idx_next = tx_idx_reg;
        tx_sh_next = tx_sh_reg;
        tx_par_next = tx_par_reg;
        tx_end = tx_cnt_reg == '0;
        case (tx_state_reg)
            S_IDLE: begin
                if (tx_valid && eff_toggle) begin
                    tx_state_next = S_LEAD;
                    dly_next = spu_ms_cycles(cfg.rts_on_ms);
                end else if (tx_valid) begin
                    tx_state_next = S_WAIT;
                end
            end
            S_LEAD: begin
                if (dly_reg == '0) begin
                    tx_state_next = S_WAIT;
                end else begin
                    dly_next = CW'(dly_reg - 1'b1);
                end
            end
            S_WAIT: begin
                if (tx_valid && tx_ready_reg) begin
                    tx_state_next = S_START;
                    tx_sh_next = tx_data;
                    tx_par_next = spu_parity(tx_data, cfg.parity, cfg.data8);
                    tx_cnt_next = CW'(bit_cyc - 1'b1);
                end else if (!tx_valid && eff_toggle) begin
                    tx_state_next = S_LAG;
                    dly_next = spu_ms_cycles(cfg.rts_off_ms);
                end else if (!tx_valid) begin
                    tx_state_next = S_IDLE;
                end
            end
            S_START: begin
                if (tx_end) begin
                    tx_state_next = S_DATA;
                    tx_idx_next = 3'h0;
                end
            end
            S_DATA: begin
                if (tx_end) begin
                    tx_sh_next = {1'b0, tx_sh_reg[7:1]};
                    tx_idx_next = 3'(tx_idx_reg + 1'b1);
                    if (tx_idx_reg == (cfg.data8 ? `SPU_DATA_TOP8 : `SPU_DATA_TOP7)) begin
                        tx_state_next = (cfg.parity == spu_pkg::SPU_PAR_NONE) ? S_STOP : S_PARITY;
                        tx_idx_next = 3'h0;
                    end
                end
            end
            S_PARITY: begin
                if (tx_end) begin
                    tx_state_next = S_STOP;
                end
            end
            S_STOP: begin
                if (tx_end && cfg.stop2 && tx_idx_reg == 3'h0) begin
                    tx_idx_next = 3'h1;
                end else if (tx_end) begin
                    tx_state_next = S_WAIT;
                end
            end
            S_LAG: begin
                if (tx_valid) begin
                    tx_state_next = S_WAIT;
                end else if (dly_reg == '0) begin
                    tx_state_next = S_IDLE;
                end else begin
                    dly_next = CW'(dly_reg - 1'b1);
                end
            end
            default: tx_state_next = S_IDLE;
        endcase
        case (tx_state_next)
            S_START: txd_next = 1'b0;
            S_DATA: txd_next = tx_sh_next[0];
            S_PARITY: txd_next = tx_par_next;
            default: txd_next = `SPU_IDLE_LINE;
        endcase
        tx_ready_next = (tx_state_next == S_WAIT) && (!eff_hs || cts_s);
        if (eff_toggle) begin
            rts_next = tx_state_next != S_IDLE;
        end else if (eff_hs) begin
            rts_next = accept_ok;
        end else begin
            rts_next = 1'b1;
        end
        // RS-485 drives only while a character is on the wire
        drv_next = !is_485 || (tx_state_next inside {S_START, S_DATA, S_PARITY, S_STOP});
        rcv_next = !(cfg.line == spu_pkg::SPU_LINE_485_2W && drv_next);
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            tx_state_reg <= S_IDLE;
            tx_cnt_reg <= '0;
            dly_reg <= '0;
            tx_idx_reg <= 3'h0;
            tx_sh_reg <= 8'h00;
            tx_par_reg <= 1'b0;
            txd_reg <= `SPU_IDLE_LINE;
            rts_reg <= 1'b0;
            tx_ready_reg <= 1'b0;
            drv_reg <= 1'b0;
            rcv_reg <= 1'b1;
        end else if (clk_en) begin
            tx_state_reg <= tx_state_next;
            tx_cnt_reg <= tx_cnt_next;
            dly_reg <= dly_next;
            tx_idx_reg <= tx_idx_next;
            tx_sh_reg <= tx_sh_next;
            tx_par_reg <= tx_par_next;
            txd_reg <= txd_next;
            rts_reg <= rts_next;
            tx_ready_reg <= tx_ready_next;
            drv_reg <= drv_next;
            rcv_reg <= rcv_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    spu_rx_state_t rx_state_reg, rx_state_next;
    logic [CW-1:0] rx_cnt_reg, rx_cnt_next;
    logic [2:0] rx_idx_reg, rx_idx_next;
    logic [7:0] rx_sh_reg, rx_sh_next, rx_data;
    logic rx_par_reg, rx_par_next, ovr_reg, ovr_next, rx_line;

    // Two-wire RS-485 hears its own echo, so the line reads idle while driving
    assign rx_line = rcv_reg ? rxd_s : `SPU_IDLE_LINE;
    assign rx_data = cfg.data8 ? rx_sh_reg : {1'b0, rx_sh_reg[7:1]};

    always_comb begin
        rx_state_next = rx_state_reg;
        rx_cnt_next = CW'(rx_cnt_reg - 1'b1);
        rx_idx_next = rx_idx_reg;
        rx_sh_next = rx_sh_reg;
        rx_par_next = rx_par_reg;
        push = 1'b0;
        push_word.data = rx_data;
        push_word.parity_err = (cfg.parity != spu_pkg::SPU_PAR_NONE) &&
                               (rx_par_reg != spu_parity(rx_data, cfg.parity, cfg.data8));
        push_word.frame_err = !rx_line;
        case (rx_state_reg)
            R_IDLE: begin
                if (!rx_line) begin
                    rx_state_next = R_START;
                    rx_cnt_next = CW'((bit_cyc >> 1) - 1'b1);
                end
            end
            R_START: begin
                if (rx_cnt_reg == '0) begin
                    // A start shorter than half a bit is noise
                    rx_state_next = rx_line ? R_IDLE : R_DATA;
                    rx_cnt_next = CW'(bit_cyc - 1'b1);
                    rx_idx_next = 3'h0;
                end
            end
            R_DATA: begin
                if (rx_cnt_reg == '0) begin
                    rx_cnt_next = CW'(bit_cyc - 1'b1);
                    rx_sh_next = {rx_line, rx_sh_reg[7:1]};
                    rx_idx_next = 3'(rx_idx_reg + 1'b1);
                    if (rx_idx_reg == (cfg.data8 ? `SPU_DATA_TOP8 : `SPU_DATA_TOP7)) begin
                        rx_state_next = (cfg.parity == spu_pkg::SPU_PAR_NONE) ? R_STOP : R_PARITY;
                    end
                end
            end
            R_PARITY: begin
                if (rx_cnt_reg == '0) begin
                    rx_par_next = rx_line;
                    rx_state_next = R_STOP;
                    rx_cnt_next = CW'(bit_cyc - 1'b1);
                end
            end
            R_STOP: begin
                // Only the first stop bit is checked; a low stop waits for mark
                if (rx_cnt_reg == '0) begin
                    push = 1'b1;
                    rx_state_next = rx_line ? R_IDLE : R_BREAK;
                end
            end
            R_BREAK: if (rx_line) rx_state_next = R_IDLE;
            default: rx_state_next = R_IDLE;
        endcase
        ovr_next = push && !accept_ok;
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            rx_state_reg <= R_IDLE;
            rx_cnt_reg <= '0;
            rx_idx_reg <= 3'h0;
            rx_sh_reg <= 8'h00;
            rx_par_reg <= 1'b0;
            ovr_reg <= 1'b0;
        end else if (clk_en) begin
            rx_state_reg <= rx_state_next;
            rx_cnt_reg <= rx_cnt_next;
            rx_idx_reg <= rx_idx_next;
            rx_sh_reg <= rx_sh_next;
            rx_par_reg <= rx_par_next;
            ovr_reg <= ovr_next;
        end
    end

    spu_fifo #(.WIDTH($bits(spu_pkg::spu_rx_word_t)), .DEPTH(DEPTH)) u_rx_fifo (
        .clock(clock),
        .sys_rst(sys_rst),
        .clk_en(clk_en),
        .in_valid(push && accept_ok),
        .in_data(push_word),
        .in_ready(fifo_in_ready),
        .out_valid(rx_valid),
        .out_ready(rx_ready),
        .out_data(rx_word),
        .empty(fifo_empty)
    );

    assign tx_ready = tx_ready_reg;
    assign txd = txd_reg;
    assign rts = rts_reg;
    assign drv_en = drv_reg;
    assign rcv_en = rcv_reg;
    assign rx_overrun = ovr_reg;

    ////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge clock); endclocking
    default disable iff (sys_rst);
    rts_idle_off_a: assert property (eff_toggle && tx_state_reg == S_IDLE && $stable(cfg) |-> !rts_reg)
        else $error("rts on with nothing pending");
    start_under_rts_a: assert property (eff_toggle && tx_state_reg == S_START |-> rts_reg)
        else $error("start bit without rts");
    lead_wait_a: assert property (clk_en && eff_toggle && $rose(rts_reg) && cfg.rts_on_ms != 7'h00
                                  |=> txd_reg)
        else $error("start bit before lead time");
    lag_hold_a: assert property (tx_state_reg == S_LAG && $stable(cfg) |-> rts_reg)
        else $error("rts dropped during lag");
    toggle_232_a: assert property (!is_232 && $stable(cfg)
                                   |=> !(tx_state_reg inside {S_LEAD, S_LAG}))
        else $error("toggle timing outside rs232");
    delay_scope_a: assert property (tx_state_reg == S_IDLE && !eff_toggle && $stable(cfg)
                                    |=> tx_state_reg != S_LEAD)
        else $error("lead delay used outside toggle mode");
    cts_gate_a: assert property (clk_en && eff_hs && $rose(tx_ready_reg) |-> $past(cts_s))
        else $error("ready raised while cts off");
    rts_room_a: assert property (clk_en && eff_hs && $stable(cfg) |=> rts_reg == $past(accept_ok))
        else $error("rts does not follow receive room");
    mark_bit_a: assert property (tx_state_reg == S_PARITY && cfg.parity == spu_pkg::SPU_PAR_MARK
                                 && $stable(cfg) |-> txd_reg)
        else $error("mark parity bit not one");
    idle_quiet_a: assert property (is_485 && tx_state_reg == S_IDLE && $stable(cfg) |-> !drv_en)
        else $error("rs485 driver on while idle");
    toggle_frame_c: cover property (eff_toggle && tx_state_reg == S_LAG);
    rx_char_c: cover property (push && accept_ok);
    cts_stall_c: cover property (eff_hs && tx_state_reg == S_WAIT && tx_valid && !cts_s);
    overrun_c: cover property (ovr_reg);
endmodule : spu_uart

// [spu_field_dev.sv]
// Field device model facing the serial port lines
`timescale 1ns/100ps
module spu_field_dev (
    input wire logic clock,
    input wire logic txd,
    input wire logic hold_off,
    input wire logic [15:0] bit_cyc,
    input wire logic [3:0] nbits,
    output logic rxd,
    output logic cts,
    output logic [10:0] got,
    output logic [7:0] n_got
);
    ////////////////////////////////////////////////////////////////////////////
    // Line idles at mark, so rxd leaves 1 only inside a frame
    initial begin
        rxd = 1'b1;
        got = 11'h000;
        n_got = 8'h00;
    end
    assign cts = !hold_off;
    // Samples mid-bit with the same settings as the block
    always begin
        @(negedge txd);
        repeat (bit_cyc / 2) @(posedge clock);
        for (int i = 0; i < nbits; i++) begin
            repeat (bit_cyc) @(posedge clock);
            got[i] = txd;
        end
        n_got = n_got + 8'h01;
    end
    // Bits after the start bit, LSB first, then back to idle
    task automatic send(input logic [10:0] f, input logic [3:0] n);
        @(posedge clock);
        #1;
        rxd = 1'b0;
        for (int i = 0; i <= n; i++) begin
            repeat (bit_cyc) @(posedge clock);
            #1;
            rxd = (i < n) ? f[i] : 1'b1;
        end
    endtask : send
endmodule : spu_field_dev

// [spu_uart_test.sv]
// Self-checking bench for the serial port
`timescale 1ns/100ps
module spu_uart_test;
    typedef struct packed {
        logic [4:0] rate;
        spu_pkg::spu_parity_t par;
        logic d8;
        logic s2;
        logic [7:0] d;
    } spu_row_t;
    localparam int CPM = 4;
    logic clock, sys_rst, tx_valid, tx_ready, rx_valid, rx_ready, rx_overrun;
    logic rxd, cts, txd, rts, drv_en, rcv_en, hold_off, seen_ovr;
    logic [7:0] tx_data, n_got;
    logic [15:0] bit_cyc;
    logic [3:0] nbits;
    logic [10:0] got;
    spu_pkg::spu_cfg_t cfg;
    spu_pkg::spu_rx_word_t rx_word;
    int errors = 0;
    int n_checks = 0;
    spu_row_t rows [6] = '{
        '{5'h13, spu_pkg::SPU_PAR_NONE, 1'b1, 1'b0, 8'ha5},
        '{5'h12, spu_pkg::SPU_PAR_ODD, 1'b1, 1'b0, 8'h3c},
        '{5'h13, spu_pkg::SPU_PAR_EVEN, 1'b1, 1'b1, 8'h01},
        '{5'h13, spu_pkg::SPU_PAR_MARK, 1'b0, 1'b0, 8'h55},
        '{5'h13, spu_pkg::SPU_PAR_SPACE, 1'b0, 1'b1, 8'hff},
        '{5'h13, spu_pkg::SPU_PAR_ODD, 1'b0, 1'b0, 8'h00}};
    spu_uart #(.CYC_PER_MS(CPM), .DEPTH(16)) u_spu_uart (.clock(clock), .sys_rst(sys_rst),
        .clk_en(1'b1), .cfg(cfg), .tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready),
        .rx_valid(rx_valid), .rx_word(rx_word), .rx_ready(rx_ready), .rx_overrun(rx_overrun),
        .rxd(rxd), .cts(cts), .txd(txd), .rts(rts), .drv_en(drv_en), .rcv_en(rcv_en));
    spu_field_dev u_spu_field_dev (.clock(clock), .txd(txd), .hold_off(hold_off),
        .bit_cyc(bit_cyc), .nbits(nbits), .rxd(rxd), .cts(cts), .got(got), .n_got(n_got));
    ////////////////////////////////////////////////////////////////////////////
    function automatic logic [10:0] frame(input spu_row_t r, output logic [3:0] n);
        logic [10:0] f;
        logic [3:0] nd;
        logic p;
        nd = r.d8 ? 4'h8 : 4'h7;
        f = 11'h7ff;
        for (int i = 0; i < nd; i++) f[i] = r.d[i];
        p = ^(r.d & (r.d8 ? 8'hff : 8'h7f));
        case (r.par)
            spu_pkg::SPU_PAR_ODD: p = ~p;
            spu_pkg::SPU_PAR_MARK: p = 1'b1;
            spu_pkg::SPU_PAR_SPACE: p = 1'b0;
            default: ;
        endcase
        if (r.par != spu_pkg::SPU_PAR_NONE) f[nd] = p;
        n = 4'(nd + (r.par != spu_pkg::SPU_PAR_NONE) + (r.s2 ? 2 : 1));
        return f;
    endfunction : frame
    task automatic chk_sig(input logic g, input logic e, input string s);
        n_checks++;
        if (g !== e) begin errors++; $display("CHECK FAILED %0t %s", $time, s); end
    endtask : chk_sig
    task automatic chk_bits(input logic [10:0] g, input logic [10:0] e);
        n_checks++;
        if (g !== e) begin errors++; $display("CHECK FAILED %0t frame %h not %h", $time, g, e); end
    endtask : chk_bits
    task automatic chk_word(input spu_pkg::spu_rx_word_t g, input spu_pkg::spu_rx_word_t e);
        n_checks++;
        if (g !== e) begin errors++; $display("CHECK FAILED %0t rx %h not %h", $time, g, e); end
    endtask : chk_word
    task automatic tick(input int k);
        repeat (k) @(posedge clock);
        #1;
    endtask : tick
    task automatic put_tx(input logic [7:0] d, output int lat);
        lat = 0;
        tx_data = d;
        tx_valid = 1'b1;
        do begin @(posedge clock); lat++; end while (tx_ready !== 1'b1 && lat < 60000);
        #1;
        tx_valid = 1'b0;
    endtask : put_tx
    task automatic wait_got(input int k);
        int w;
        w = 0;
        while (int'(n_got) != k && w < 5000) begin tick(1); w++; end
        chk_sig(int'(n_got) == k, 1'b1, "no frame on txd");
    endtask : wait_got
    task automatic get_rx(input spu_pkg::spu_rx_word_t e);
        int w;
        w = 0;
        while (rx_valid !== 1'b1 && w < 5000) begin tick(1); w++; end
        chk_word(rx_word, e);
        rx_ready = 1'b1;
        tick(1);
        rx_ready = 1'b0;
    endtask : get_rx
    task automatic wrap_up();
        if (errors == 0 && n_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : wrap_up
    always @(posedge clock) if (rx_overrun === 1'b1) seen_ovr <= 1'b1;
    initial begin
        clock = 1'b0;
        forever #4 clock = ~clock;
    end
    // Whole run needs about 60k cycles
    initial begin
        repeat (90000) @(posedge clock);
        errors++;
        wrap_up();
    end
    ////////////////////////////////////////////////////////////////////////////
    initial begin : main
        logic [10:0] f;
        logic [3:0] n;
        spu_row_t r;
        int lat;
        int k;
        sys_rst = 1'b1;
        tx_valid = 1'b0;
        tx_data = 8'h00;
        rx_ready = 1'b0;
        hold_off = 1'b0;
        seen_ovr = 1'b0;
        bit_cyc = 16'h0087;
        nbits = 4'h9;
        cfg = '{5'h13, spu_pkg::SPU_PAR_NONE, 1'b1, 1'b0, spu_pkg::SPU_FLOW_NONE, 1'b1,
            spu_pkg::SPU_LINE_232, 7'h64, 7'h64};
        tick(15);
        chk_sig(txd, 1'b1, "txd in reset");
        chk_sig(rts | tx_ready | rx_valid, 1'b0, "outputs in reset");
        tick(1);
        sys_rst = 1'b0;
        foreach (rows[i]) begin
            r = rows[i];
            cfg.rate_sel = r.rate;
            cfg.parity = r.par;
            cfg.data8 = r.d8;
            cfg.stop2 = r.s2;
            bit_cyc = 16'(125000000 / (r.rate == 5'h13 ? 921600 : 460800));
            f = frame(r, n);
            nbits = n;
            tick(2);
            k = int'(n_got);
            put_tx(r.d, lat);
            chk_sig(lat <= 3 && rts === 1'b1, 1'b1, "lead applied outside toggle");
            wait_got(k + 1);
            chk_bits(got & ~(11'h7ff << n), f & ~(11'h7ff << n));
            u_spu_field_dev.send(f, n);
            get_rx({r.d & (r.d8 ? 8'hff : 8'h7f), 2'b00});
        end
        u_spu_field_dev.send(f ^ 11'h080, n);
        get_rx({8'h00, 2'b10});
        u_spu_field_dev.send(f & 11'h6ff, n);
        get_rx({8'h00, 2'b01});
        cfg.flow = spu_pkg::SPU_FLOW_TOGGLE;
        cfg.rts_on_ms = 7'h02;
        cfg.rts_off_ms = 7'h03;
        tick(3);
        chk_sig(rts, 1'b0, "rts up without data");
        put_tx(8'h5a, lat);
        chk_sig(lat >= 2 * CPM + 1 && lat <= 2 * CPM + 5, 1'b1, "lead time");
        chk_sig(rts, 1'b1, "rts low at start");
        lat = 0;
        while (rts === 1'b1 && lat < 5000) begin tick(1); lat++; end
        k = (int'(n) + 1) * int'(bit_cyc) + 3 * CPM;
        chk_sig(lat >= k && lat <= k + 6, 1'b1, "release lag");
        cfg.line = spu_pkg::SPU_LINE_422;
        tick(3);
        chk_sig(rts & drv_en, 1'b1, "toggle honoured off rs232");
        cfg.flow = spu_pkg::SPU_FLOW_NONE;
        cfg.line = spu_pkg::SPU_LINE_485_2W;
        tick(3);
        chk_sig(!drv_en && rcv_en, 1'b1, "rs485 idle enables");
        put_tx(8'h0f, lat);
        tick(2);
        chk_sig(drv_en && !rcv_en, 1'b1, "rs485 frame enables");
        tick((int'(n) + 1) * int'(bit_cyc) + 4);
        chk_sig(drv_en, 1'b0, "rs485 driver kept on");
        // Handshake with the unbuffered receive path
        cfg.line = spu_pkg::SPU_LINE_232;
        cfg.flow = spu_pkg::SPU_FLOW_RTSCTS;
        cfg.fifo_en = 1'b0;
        hold_off = 1'b1;
        tick(3);
        k = int'(n_got);
        tx_data = 8'h33;
        tx_valid = 1'b1;
        tick(300);
        chk_sig(txd === 1'b1 && n_got == 8'(k), 1'b1, "sent against cts");
        hold_off = 1'b0;
        put_tx(8'h33, lat);
        wait_got(k + 1);
        u_spu_field_dev.send(f, n);
        tick(4);
        chk_sig(rts, 1'b0, "rts with no room");
        u_spu_field_dev.send(f ^ 11'h081, n);
        chk_sig(seen_ovr, 1'b1, "second char not dropped");
        get_rx({8'h00, 2'b00});
        // Fill buffer plus output stage, one more is refused, then drain in order
        cfg.fifo_en = 1'b1;
        r = rows[5];
        for (int i = 0; i < 17; i++) begin
            r.d = 8'(i);
            f = frame(r, n);
            u_spu_field_dev.send(f, n);
        end
        tick(4);
        chk_sig(rts, 1'b0, "rts with full buffer");
        seen_ovr = 1'b0;
        u_spu_field_dev.send(f, n);
        chk_sig(seen_ovr, 1'b1, "full buffer took char");
        for (int i = 0; i < 17; i++) get_rx({8'(i), 2'b00});
        tick(3);
        chk_sig(rx_valid | !rts, 1'b0, "drained state");
        wrap_up();
    end
endmodule : spu_uart_test
